// file: core/plr_top.sv
// long-press push-button reset generator, one of three variants
// assumes nrst is held low by the supply detector while the supply is
// too low; the reset pin is open drain with an external pull-up
`timescale 1ns/10ps

module plr_top import plr_pkg::*; #(
  parameter plr_variant_e VARIANT = PLR_LEVEL_DUAL,
  parameter bit LONG_PULSE = 1'b1,
  parameter logic [CNT_W-1:0] HOLD_SHORT_CYC = CYC_HOLD_SHORT,
  parameter logic [CNT_W-1:0] HOLD_LONG_CYC = CYC_HOLD_LONG,
  parameter logic [CNT_W-1:0] PULSE_SHORT_CYC = CYC_PULSE_SHORT,
  parameter logic [CNT_W-1:0] PULSE_LONG_CYC = CYC_PULSE_LONG,
  parameter logic [CNT_W-1:0] DETECT_CYC = CYC_DETECT,
  parameter logic [CNT_W-1:0] STARTUP_CYC = CYC_STARTUP
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // buttons and strap
  input wire logic button_in_a_n,
  input wire logic button_in_b_n,
  input wire logic hold_time_select,
  // open-drain reset pin
  output logic rst_n_out,
  output logic rst_n_oe,
  // status
  output logic hold_long_o
);

  localparam bit DUAL = (VARIANT != PLR_PULSE_SINGLE);
  localparam bit FIXED = (VARIANT != PLR_LEVEL_DUAL);
  localparam logic [CNT_W-1:0] ONE = 32'h1;
  localparam logic [CNT_W-1:0] PULSE_CYC =
    LONG_PULSE ? PULSE_LONG_CYC : PULSE_SHORT_CYC;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  plr_sync_if sif ();

  assign sif.raw[IDX_A] = button_in_a_n;
  assign sif.raw[IDX_B] = button_in_b_n;
  assign sif.raw[IDX_SEL] = hold_time_select;

  plr_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .sif(sif)
  );

  logic all_low, any_high, sel_in;

  // single variant never looks at button b
  assign all_low = !sif.clean[IDX_A] && (!sif.clean[IDX_B] || !DUAL);
  assign any_high = !all_low;
  assign sel_in = sif.clean[IDX_SEL];

  // ----------------------------------------------------------------
  // hold time decode
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] hold_target(input logic long_sel);
    logic [CNT_W-1:0] t;
    t = HOLD_SHORT_CYC;
    if (long_sel) begin
      // 0 s option still waits the detection delay
      t = FIXED ? DETECT_CYC : HOLD_LONG_CYC;
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  plr_state_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic sel_r, sel_nxt;
  logic drive_r, drive_nxt;
  logic val_r, val_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    drive_nxt = 1'b0;
    unique case (st_r)
      PLR_ST_START: begin
        sel_nxt = sel_in;
        if (cnt_r == STARTUP_CYC - ONE) begin
          cnt_nxt = RST_CNT;
          if (all_low && FIXED && sel_in) begin
            // buttons already low with 0 s option: assert now
            st_nxt = PLR_ST_PULSE;
            drive_nxt = 1'b1;
          end else if (all_low) begin
            st_nxt = PLR_ST_HOLD;
          end else begin
            st_nxt = PLR_ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r + ONE;
        end
      end
      PLR_ST_IDLE: begin
        if (any_high) begin
          sel_nxt = sel_in;
        end else begin
          st_nxt = PLR_ST_HOLD;
          cnt_nxt = RST_CNT;
        end
      end
      PLR_ST_HOLD: begin
        if (any_high) begin
          st_nxt = PLR_ST_IDLE;
          cnt_nxt = RST_CNT;
          sel_nxt = sel_in;
        end else if (cnt_r == hold_target(sel_r) - ONE) begin
          cnt_nxt = RST_CNT;
          drive_nxt = 1'b1;
          st_nxt = FIXED ? PLR_ST_PULSE : PLR_ST_LEVEL;
        end else begin
          cnt_nxt = cnt_r + ONE;
        end
      end
      PLR_ST_PULSE: begin
        // buttons are not looked at here at all
        drive_nxt = 1'b1;
        if (cnt_r == PULSE_CYC - ONE) begin
          drive_nxt = 1'b0;
          cnt_nxt = RST_CNT;
          st_nxt = PLR_ST_REARM;
        end else begin
          cnt_nxt = cnt_r + ONE;
        end
      end
      PLR_ST_LEVEL: begin
        drive_nxt = 1'b1;
        if (any_high) begin
          drive_nxt = 1'b0;
          st_nxt = PLR_ST_IDLE;
          sel_nxt = sel_in;
        end
      end
      PLR_ST_REARM: begin
        // a release seen only now is acted on after the pulse
        if (any_high) begin
          st_nxt = PLR_ST_IDLE;
          sel_nxt = sel_in;
        end
      end
    endcase
    val_nxt = !drive_nxt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= PLR_ST_START;
      cnt_r <= RST_CNT;
      sel_r <= RST_SEL;
      drive_r <= RST_DRIVE;
      val_r <= !RST_DRIVE;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
      drive_r <= drive_nxt;
      val_r <= val_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // enable high only while pulling the pin low; pull-up gives the high
  assign rst_n_oe = drive_r;
  assign rst_n_out = val_r;
  assign hold_long_o = sel_r;

endmodule

// file: core/plr_pkg.sv
// constants, types and timing for the long-press push-button reset block
// assumes a single 100 MHz clock and an active-low asynchronous reset
// that stands in for the supply detector
//
// Contract
// - hold is 7.5 s with strap low; strap high: 12.5 s level, 0 s pulse.
// - level dual: reset once both low for hold, off when either rises.
// - pulse dual: one fixed pulse once both low for hold, buttons aside.
// - the fixed pulse lasts 80 ms (short option) or 400 ms (long option).
// - single variant: button a only, one fixed pulse it cannot end.
// - one reset per press: a button must rise, then meet the full hold.
// - buttons ignored during a pulse; a rise is acted on after it ends.
// - strap sampled at power-up and with a button high, never all low.
// - with the 0 s option, reset asserts 150 us after both buttons low.
// - a 300 us start-up delay first; buttons already low then start the hold, or assert at once with the 0 s option.
// - reset is driven low when asserted and high impedance otherwise.
// - while the supply is too low (reset held) the output is high-Z.

package plr_pkg;

  // ----------------------------------------------------------------
  // variants and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLR_LEVEL_DUAL,
    PLR_PULSE_DUAL,
    PLR_PULSE_SINGLE
  } plr_variant_e;

  typedef enum logic [2:0] {
    PLR_ST_START,
    PLR_ST_IDLE,
    PLR_ST_HOLD,
    PLR_ST_PULSE,
    PLR_ST_LEVEL,
    PLR_ST_REARM
  } plr_state_e;

  // ----------------------------------------------------------------
  // timing, times in microseconds, counts in clock cycles
  // ----------------------------------------------------------------
  localparam int CNT_W = 32;
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned US_PER_S = 64'd1_000_000;

  localparam longint unsigned T_HOLD_SHORT_US = 64'd7_500_000;
  localparam longint unsigned T_HOLD_LONG_US = 64'd12_500_000;
  localparam longint unsigned T_PULSE_SHORT_US = 64'd80_000;
  localparam longint unsigned T_PULSE_LONG_US = 64'd400_000;
  localparam longint unsigned T_DETECT_US = 64'd150;
  localparam longint unsigned T_STARTUP_US = 64'd300;

  localparam logic [CNT_W-1:0] CYC_HOLD_SHORT =
    CNT_W'(T_HOLD_SHORT_US * CLK_HZ / US_PER_S);
  localparam logic [CNT_W-1:0] CYC_HOLD_LONG =
    CNT_W'(T_HOLD_LONG_US * CLK_HZ / US_PER_S);
  localparam logic [CNT_W-1:0] CYC_PULSE_SHORT =
    CNT_W'(T_PULSE_SHORT_US * CLK_HZ / US_PER_S);
  localparam logic [CNT_W-1:0] CYC_PULSE_LONG =
    CNT_W'(T_PULSE_LONG_US * CLK_HZ / US_PER_S);
  localparam logic [CNT_W-1:0] CYC_DETECT =
    CNT_W'(T_DETECT_US * CLK_HZ / US_PER_S);
  localparam logic [CNT_W-1:0] CYC_STARTUP =
    CNT_W'(T_STARTUP_US * CLK_HZ / US_PER_S);

  // ----------------------------------------------------------------
  // synchroniser layout and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_W = 3;
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam int IDX_SEL = 2;
  // buttons idle high, strap assumed low until seen
  localparam logic [SYNC_W-1:0] RST_SYNC = 3'h3;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h0;
  localparam logic RST_SEL = 1'b0;
  localparam logic RST_DRIVE = 1'b0;

endpackage

// file: core/plr_sync_if.sv
// raw pin levels in, filtered levels out, between top and synchroniser
// assumes both ends run on the same clock
`timescale 1ns/10ps

interface plr_sync_if import plr_pkg::*;;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;

  modport src (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

// file: core/plr_sync.sv
// three-stage synchroniser with agreement filter for the pin inputs
// assumes pins are asynchronous to clk
`timescale 1ns/10ps

module plr_sync import plr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, filtered levels out
  plr_sync_if.filt sif
);

  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, clean_r;
  logic [SYNC_W-1:0] clean_nxt;

  // ----------------------------------------------------------------
  // agreement filter
  // ----------------------------------------------------------------
  // stage one feeds only stage two, so metastability cannot leak
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    always_comb begin
      clean_nxt[i] = clean_r[i];
      if (s2_r[i] == s3_r[i]) begin
        clean_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST_SYNC;
      s2_r <= RST_SYNC;
      s3_r <= RST_SYNC;
      clean_r <= RST_SYNC;
    end else begin
      s1_r <= sif.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= clean_nxt;
    end
  end

  assign sif.clean = clean_r;

endmodule

// file: bench/plr_properties.sv
// timing checks on the push-button reset block's pins
// assumes one clock domain and is bound to every plr_top instance
`timescale 1ns/10ps

module plr_properties import plr_pkg::*; #(
  parameter plr_variant_e VARIANT = PLR_LEVEL_DUAL,
  parameter bit LONG_PULSE = 1'b1,
  parameter logic [CNT_W-1:0] HOLD_SHORT_CYC = CYC_HOLD_SHORT,
  parameter logic [CNT_W-1:0] HOLD_LONG_CYC = CYC_HOLD_LONG,
  parameter logic [CNT_W-1:0] PULSE_SHORT_CYC = CYC_PULSE_SHORT,
  parameter logic [CNT_W-1:0] PULSE_LONG_CYC = CYC_PULSE_LONG,
  parameter logic [CNT_W-1:0] DETECT_CYC = CYC_DETECT,
  parameter logic [CNT_W-1:0] STARTUP_CYC = CYC_STARTUP
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic button_in_a_n,
  input wire logic button_in_b_n,
  input wire logic rst_n_out,
  input wire logic rst_n_oe,
  input wire logic hold_long_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic lvl, mon_low, fired_r;
  logic [CNT_W-1:0] low_r, oe_r, up_r, hold, plen;
  assign lvl = VARIANT == PLR_LEVEL_DUAL;
  assign mon_low = !button_in_a_n &&
    (VARIANT == PLR_PULSE_SINGLE || !button_in_b_n);
  assign plen = LONG_PULSE ? PULSE_LONG_CYC : PULSE_SHORT_CYC;
  assign hold = !hold_long_o ? HOLD_SHORT_CYC :
    lvl ? HOLD_LONG_CYC : DETECT_CYC;
  // fired_r marks a press already served; a release or nrst clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_r <= '0;
      oe_r <= '0;
      up_r <= '0;
      fired_r <= 1'b0;
    end else begin
      low_r <= mon_low ? low_r + 1 : '0;
      oe_r <= rst_n_oe ? oe_r + 1 : '0;
      if (up_r < 32'h3ff) begin
        up_r <= up_r + 1;
      end
      if (!mon_low) begin
        fired_r <= 1'b0;
      end else if (rst_n_oe) begin
        fired_r <= 1'b1;
      end
    end
  end
  sequence s_pulse_end;
    !lvl ##0 $fell(rst_n_oe);
  endsequence
  a_drive_low: assert property (rst_n_oe |-> !rst_n_out)
    else $error("reset pin driven high");
  a_reset_quiet: assert property ($rose(nrst) |-> !rst_n_oe [*2])
    else $error("reset pin driven right after power-up");
  a_startup_wait: assert property (rst_n_oe |-> up_r >= STARTUP_CYC)
    else $error("reset before start-up delay");
  a_hold_min: assert property ($rose(rst_n_oe) |-> low_r >= hold)
    else $error("reset before hold time");
  a_hold_max: assert property (low_r == hold + 8 &&
    up_r > hold + STARTUP_CYC + 9 |-> fired_r)
    else $error("reset late after hold time");
  a_pulse_len: assert property (s_pulse_end |-> oe_r == plen)
    else $error("reset pulse length wrong");
  a_one_press: assert property ($rose(rst_n_oe) |-> !fired_r)
    else $error("second reset without release");
  a_strap_frozen: assert property (low_r > 8 &&
    up_r > STARTUP_CYC + 8 |-> $stable(hold_long_o))
    else $error("hold select changed while buttons low");
endmodule

bind plr_top plr_properties #(.VARIANT(VARIANT), .LONG_PULSE(LONG_PULSE),
  .HOLD_SHORT_CYC(HOLD_SHORT_CYC), .HOLD_LONG_CYC(HOLD_LONG_CYC),
  .PULSE_SHORT_CYC(PULSE_SHORT_CYC), .PULSE_LONG_CYC(PULSE_LONG_CYC),
  .DETECT_CYC(DETECT_CYC), .STARTUP_CYC(STARTUP_CYC)) plr_properties_inst (
  .clk(clk), .nrst(nrst), .button_in_a_n(button_in_a_n),
  .button_in_b_n(button_in_b_n), .rst_n_out(rst_n_out),
  .rst_n_oe(rst_n_oe), .hold_long_o(hold_long_o));

// file: bench/plr_partner.sv
// two switches with pull-ups and the processor's pulled-up reset line
// assumes the block's reset pin is open drain
`timescale 1ns/10ps

module plr_partner (
  // presses from the bench, high = held down
  input wire logic press_a,
  input wire logic press_b,
  // block side
  input wire logic rst_n_oe,
  input wire logic rst_n_out,
  output logic button_a_n,
  output logic button_b_n,
  output logic rst_line_n
);
  // a released switch leaves the pull-up in charge
  assign button_a_n = !press_a;
  assign button_b_n = !press_b;
  assign rst_line_n = rst_n_oe ? rst_n_out : 1'b1;
endmodule

// file: bench/pushbutton_long_press_reset_test.sv
// bench for the fixed-pulse dual-button variant with shortened counts
// assumes plr_partner stands for the switches and the reset line
`timescale 1ns/10ps

module pushbutton_long_press_reset_test import plr_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic press_a = 1'b1;
  logic press_b = 1'b1;
  logic sel = 1'b0;
  logic btn_a_n, btn_b_n, oe, out_n, long_o, line_n;
  int err_total = 0;
  int n_compared = 0;
  int n;
  initial forever #5 clk = ~clk;
  plr_partner plr_partner_inst (.press_a(press_a), .press_b(press_b),
    .rst_n_oe(oe), .rst_n_out(out_n), .button_a_n(btn_a_n),
    .button_b_n(btn_b_n), .rst_line_n(line_n));
  plr_top #(.VARIANT(PLR_PULSE_DUAL), .HOLD_SHORT_CYC(32'h28),
    .PULSE_SHORT_CYC(32'ha),
    .PULSE_LONG_CYC(32'h14), .DETECT_CYC(32'h5), .STARTUP_CYC(32'h8))
    plr_top_inst (.clk(clk), .nrst(nrst), .button_in_a_n(btn_a_n),
    .button_in_b_n(btn_b_n), .hold_time_select(sel),
    .rst_n_out(out_n), .rst_n_oe(oe), .hold_long_o(long_o));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic push(logic a, logic b);
    @(posedge clk);
    press_a <= a;
    press_b <= b;
  endtask
  task automatic to_oe(output int k);
    k = 0;
    while (oe !== 1'b1 && k < 99) begin
      cyc(1);
      k++;
    end
    if (k >= 99) begin
      err_total++;
    end
  endtask
  task automatic plen(output int k);
    k = 0;
    while (oe === 1'b1 && k < 99) begin
      cyc(1);
      k++;
    end
    if (k >= 99) begin
      err_total++;
    end
  endtask
  task automatic t_startup;
    to_oe(n);
    chk("startup_delay", n inside {[47:52]}, 1);
    plen(n);
    chk("pulse_len", n, 20);
    cyc(60);
    chk("one_reset", oe, 0);
    $display("done startup");
  endtask
  task automatic t_abort;
    push(0, 0);
    cyc(10);
    push(1, 1);
    cyc(30);
    push(0, 0);
    cyc(10);
    push(1, 1);
    to_oe(n);
    chk("hold_restart", n inside {[45:47]}, 1);
    plen(n);
    chk("pulse_len", n, 20);
    push(0, 0);
    cyc(10);
    push(1, 0);
    cyc(70);
    chk("pair_needed", oe, 0);
    $display("done abort");
  endtask
  task automatic t_glitch;
    push(1, 1);
    to_oe(n);
    fork
      plen(n);
      begin
        push(0, 1);
        push(1, 1);
        cyc(3);
        push(1, 0);
      end
    join
    chk("pulse_glitch", n, 20);
    push(1, 1);
    to_oe(n);
    chk("after_release", n inside {[45:47]}, 1);
    plen(n);
    $display("done glitch");
  endtask
  task automatic t_strap;
    push(0, 0);
    sel <= 1'b1;
    cyc(10);
    chk("strap_seen", long_o, 1);
    push(1, 1);
    to_oe(n);
    chk("detect_delay", n inside {[10:12]}, 1);
    chk("line_low", line_n, 0);
    @(posedge clk);
    sel <= 1'b0;
    plen(n);
    cyc(5);
    chk("strap_frozen", long_o, 1);
    push(0, 0);
    cyc(10);
    chk("strap_follow", long_o, 0);
    chk("line_high", line_n, 1);
    $display("done strap");
  endtask
  task automatic t_por;
    push(1, 1);
    to_oe(n);
    @(posedge clk);
    nrst <= 1'b0;
    cyc(1);
    chk("por_quiet", oe, 0);
    chk("por_line", line_n, 1);
    push(1, 1);
    nrst <= 1'b1;
    to_oe(n);
    chk("restart_delay", n inside {[47:52]}, 1);
    plen(n);
    chk("pulse_len", n, 20);
    $display("done power-up");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_startup;
    t_abort;
    t_glitch;
    t_strap;
    t_por;
    end_of_test;
  end
  // the whole run is under a thousand cycles
  initial begin
    #50000;
    err_total++;
    end_of_test;
  end
endmodule
